// ===== src/pic_host_side.sv
// eight-level priority interrupt controller, processor facing part
`timescale 1ns/1ps
`include "pic_map.svh"
module pic_host_side (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// processor bus pins
	input  wire logic       chip_sel_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       address_bit_zero,
	input  wire logic       interrupt_acknowledge_strobe_n,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            int_out,
	// peripheral requests
	input  wire logic [7:0] request_lines,
	// cascade bus
	input  wire logic [2:0] cascade_lines_in,
	output logic      [2:0] cascade_lines_out,
	output logic            cascade_lines_oe,
	// slave program in, buffer enable out
	input  wire logic       slave_program_in,
	output logic            buffer_enable_n,
	output logic            slave_program_oe
);
	// every input pin except clk and sys_rst goes through two flops; a third stage gives edges
	localparam int PW = 25;
	logic [PW-1:0] pin_s1_q;
	logic [PW-1:0] pin_s2_q;
	logic [PW-1:0] pin_s3_q;
	wire  [PW-1:0] pin_raw = {chip_sel_n, rd_n, wr_n, address_bit_zero,
		interrupt_acknowledge_strobe_n, slave_program_in,
		cascade_lines_in, request_lines, data_in};
	always_ff @(posedge clk) begin
		pin_s1_q <= pin_raw;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end
	wire       cs_n    = pin_s2_q[24];
	wire       rdn     = pin_s2_q[23];
	wire       wrn     = pin_s2_q[22];
	wire       ack_ns  = pin_s2_q[20];
	wire       sp_in   = pin_s2_q[19];
	wire [2:0] cas_in  = pin_s2_q[18:16];
	wire [7:0] req_now = pin_s2_q[15:8];
	wire       cs_n_p  = pin_s3_q[24];
	wire       rdn_p   = pin_s3_q[23];
	wire       wrn_p   = pin_s3_q[22];
	wire       ad0_p   = pin_s3_q[21];
	wire       ack_np  = pin_s3_q[20];
	wire [7:0] din_p   = pin_s3_q[7:0];

	// control state
	pic_pkg::pic_init_t state_q;
	logic       lvlt_q;
	logic       iv4_q;
	logic       solo_q;
	logic       w4n_q;
	logic [2:0] page_lo_q;
	logic [7:0] word2_q;
	logic [7:0] casc_q;
	logic       pm_q;
	logic       auto_q;
	logic       ms_q;
	logic       buf_q;
	logic       nest_q;
	logic [7:0] mask_q;
	logic [7:0] pnd_q;
	logic [7:0] svc_q;
	logic [7:0] req_prev_q;
	logic [2:0] low_q;
	logic       rd_svc_q;
	logic       poll_q;
	logic       smm_q;
	logic [1:0] ack_cnt_q;
	logic [2:0] lvl_q;
	logic       hand_off_q;
	logic       int_q;
	logic [7:0] dout_q;
	logic [2:0] cas_out_q;
	logic       cas_oe_q;

	// strobes: write and read taken at the trailing edge so the data has settled, ack at both edges
	wire wr_fire  = ~wrn_p & wrn & ~cs_n_p;
	wire rd_end   = ~rdn_p & rdn & ~cs_n_p;
	wire ack_fall = ack_np & ~ack_ns;
	wire ack_rise = ~ack_np & ack_ns;
	wire ready    = (state_q == pic_pkg::ST_READY);

	// write decode
	wire w_init1 = wr_fire & ~ad0_p & din_p[`PIC_W1_SEL];
	wire w_eoi   = wr_fire & ~ad0_p & ~din_p[`PIC_W1_SEL]
		& ~din_p[`PIC_CMD_SEL];
	wire w_rdp   = wr_fire & ~ad0_p & ~din_p[`PIC_W1_SEL]
		& din_p[`PIC_CMD_SEL];
	wire w_odd   = wr_fire & ad0_p;

	// roles: buffered mode takes the role from the fourth word
	wire cascaded  = ~solo_q;
	wire is_master = buf_q ? ms_q : sp_in;
	wire master    = cascaded & is_master;
	wire slave     = cascaded & ~is_master;

	// priority resolution, lowest level held in low_q
	function automatic logic [3:0] pick(input logic [7:0] v,
		input logic [2:0] low);
		logic [3:0] r;
		logic [2:0] idx;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			idx = 3'(low + 3'(i) + 3'h1);
			if (v[idx])
				r = {1'b1, idx};
		end
		return r;
	endfunction : pick

	function automatic logic [2:0] rank(input logic [2:0] l,
		input logic [2:0] low);
		return 3'(l - low - 3'h1);
	endfunction : rank

	wire [7:0] req_cand = pnd_q & ~mask_q;
	wire [7:0] svc_eff  = smm_q ? (svc_q & ~mask_q) : svc_q;
	wire [3:0] req_pick = pick(req_cand, low_q);
	wire [3:0] svc_pick = pick(svc_eff, low_q);
	wire [3:0] top_pnd  = pick(pnd_q, low_q);
	wire [2:0] req_lvl  = req_pick[2:0];
	wire [2:0] req_rank = rank(req_lvl, low_q);
	wire [2:0] svc_rank = rank(svc_pick[2:0], low_q);
	wire       nest_ok  = nest_q & master ? req_rank <= svc_rank
		: req_rank < svc_rank;
	wire       int_d    = ready & req_pick[3]
		& (~svc_pick[3] | nest_ok);
	// freeze on the first ack: highest unmasked request while int is up, else highest pending with mask not consulted
	wire [2:0] ack_lvl  = int_q ? req_lvl : top_pnd[2:0];
	wire       ack_go   = ready & ack_fall & (ack_cnt_q == 2'd0);
	wire       last_ack = pm_q ? (ack_cnt_q == 2'd1)
		: (ack_cnt_q == 2'd2);
	wire       via_slave = master & casc_q[ack_lvl];

	// answer bytes
	wire [7:0] call_low = iv4_q
		? {page_lo_q, lvl_q, 2'b00}
		: {page_lo_q[2:1], lvl_q, 3'b000};
	wire [7:0] vec_byte = {word2_q[7:3], lvl_q};
	wire       id_match = (cas_in == casc_q[2:0]);
	wire       may_send = ~hand_off_q & (~slave | id_match);
	logic [7:0] ack_byte;
	logic       ack_send;
	always_comb begin
		ack_byte = `PIC_CALL_OPCODE;
		ack_send = 1'b0;
		unique case (ack_cnt_q)
			2'd0: begin
				ack_byte = `PIC_CALL_OPCODE;
				ack_send = ready & ~pm_q & ~slave;
			end
			2'd1: begin
				ack_byte = pm_q ? vec_byte : call_low;
				ack_send = may_send;
			end
			2'd2: begin
				ack_byte = word2_q;
				ack_send = may_send & ~pm_q;
			end
			default: begin
				ack_byte = 8'h00;
				ack_send = 1'b0;
			end
		endcase
	end
	wire [7:0] poll_byte = {int_q, 4'h0, req_lvl};
	wire [7:0] stat_byte = poll_q ? poll_byte
		: rd_svc_q ? svc_q : pnd_q;
	wire [7:0] rd_byte   = pin_s2_q[21] ? mask_q : stat_byte;
	wire       rd_act    = ~cs_n & ~rdn & wrn;
	wire       ack_act   = ~ack_ns & ack_send;
	wire [7:0] dout_d    = ~ack_ns ? ack_byte : rd_byte;

	// requests: edge or level sensing
	wire [7:0] edge_hit = req_now & ~req_prev_q;
	wire [7:0] pnd_set  = lvlt_q ? req_now : edge_hit;
	wire [7:0] lvl_mask = lvlt_q ? req_now : 8'hff;
	wire [7:0] ack_clr  = ack_go ? 8'(1) << ack_lvl : 8'h00;
	wire       poll_take = rd_end & poll_q & ~pin_s3_q[21]
		& req_pick[3];
	wire [7:0] poll_clr = poll_take ? 8'(1) << req_lvl : 8'h00;

	// end of interrupt clears
	wire       eoi_cmd  = w_eoi & din_p[`PIC_EOI_BIT];
	wire [2:0] eoi_lvl  = din_p[`PIC_SL_BIT] ? din_p[2:0]
		: svc_pick[2:0];
	wire [7:0] eoi_clr  = eoi_cmd ? 8'(1) << eoi_lvl : 8'h00;
	wire [7:0] auto_clr = (auto_q & ack_rise & last_ack)
		? 8'(1) << lvl_q : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst | w_init1) begin
			mask_q     <= 8'h00;
			pnd_q      <= 8'h00;
			req_prev_q <= 8'hff;
			low_q      <= `PIC_LOW_RESET;
			smm_q      <= 1'b0;
			rd_svc_q   <= 1'b0;
			poll_q     <= 1'b0;
		end else begin
			req_prev_q <= req_now;
			// a fresh edge beats the ack clear, so none is lost
			pnd_q      <= ((pnd_q & ~ack_clr & ~poll_clr) | pnd_set)
				& lvl_mask;
			if (w_odd & ready)
				mask_q <= din_p;
			if (w_rdp & din_p[`PIC_RD_RR])
				rd_svc_q <= din_p[`PIC_RD_RIS];
			if (w_rdp & din_p[`PIC_RD_ESMM])
				smm_q <= din_p[`PIC_RD_SMM];
			if (w_rdp)
				poll_q <= din_p[`PIC_RD_POLL];
			else if (rd_end & ~pin_s3_q[21])
				poll_q <= 1'b0;
			if (w_eoi & din_p[`PIC_ROT_BIT] & din_p[`PIC_SL_BIT])
				low_q <= din_p[2:0];
			else if (eoi_cmd & din_p[`PIC_ROT_BIT])
				low_q <= eoi_lvl;
		end
	end

	// in-service register: set on acknowledge, cleared by end commands
	always_ff @(posedge clk) begin
		if (sys_rst | w_init1)
			svc_q <= 8'h00;
		else
			svc_q <= (svc_q & ~eoi_clr & ~auto_clr)
				| ack_clr | poll_clr;
	end

	// initialization sequence
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= pic_pkg::ST_UNINIT;
			lvlt_q    <= 1'b0;
			iv4_q     <= 1'b0;
			solo_q    <= 1'b1;
			w4n_q     <= 1'b0;
			page_lo_q <= 3'h0;
			word2_q   <= 8'h00;
			casc_q    <= 8'h00;
			pm_q      <= 1'b0;
			auto_q    <= 1'b0;
			ms_q      <= 1'b0;
			buf_q     <= 1'b0;
			nest_q    <= 1'b0;
		end else if (w_init1) begin
			state_q   <= pic_pkg::ST_WORD2;
			lvlt_q    <= din_p[`PIC_W1_LVLT];
			iv4_q     <= din_p[`PIC_W1_IV4];
			solo_q    <= din_p[`PIC_W1_SOLO];
			w4n_q     <= din_p[`PIC_W1_W4N];
			page_lo_q <= din_p[7:5];
			if (!din_p[`PIC_W1_W4N]) begin
				pm_q   <= 1'b0;
				auto_q <= 1'b0;
				buf_q  <= 1'b0;
				nest_q <= 1'b0;
			end
		end else if (w_odd) begin
			unique case (state_q)
				pic_pkg::ST_WORD2: begin
					word2_q <= din_p;
					state_q <= !solo_q ? pic_pkg::ST_WORD3
						: w4n_q ? pic_pkg::ST_WORD4
						: pic_pkg::ST_READY;
				end
				pic_pkg::ST_WORD3: begin
					casc_q  <= din_p;
					state_q <= w4n_q ? pic_pkg::ST_WORD4
						: pic_pkg::ST_READY;
				end
				pic_pkg::ST_WORD4: begin
					pm_q    <= din_p[`PIC_W4_PM];
					auto_q  <= din_p[`PIC_W4_AUTO];
					ms_q    <= din_p[`PIC_W4_MS];
					buf_q   <= din_p[`PIC_W4_BUF];
					nest_q  <= din_p[`PIC_W4_NEST];
					state_q <= pic_pkg::ST_READY;
				end
				pic_pkg::ST_UNINIT,
				pic_pkg::ST_READY: state_q <= state_q;
			endcase
		end
	end

	// acknowledge sequence and cascade drive
	always_ff @(posedge clk) begin
		if (sys_rst | w_init1) begin
			ack_cnt_q  <= 2'd0;
			lvl_q      <= 3'h0;
			hand_off_q <= 1'b0;
			cas_out_q  <= 3'h0;
			cas_oe_q   <= 1'b0;
		end else begin
			if (ack_go) begin
				// a slave answers with its own level, never its id
				lvl_q      <= ack_lvl;
				hand_off_q <= via_slave;
				cas_out_q  <= via_slave ? ack_lvl : 3'h0;
			end
			if (ack_rise)
				ack_cnt_q <= last_ack ? 2'd0
					: 2'(ack_cnt_q + 2'd1);
			if (ack_rise & last_ack) begin
				cas_out_q  <= 3'h0;
				hand_off_q <= 1'b0;
			end
			cas_oe_q <= master;
		end
	end
	// request and output byte registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			int_q  <= 1'b0;
			dout_q <= 8'h00;
		end else begin
			int_q  <= int_d & ~poll_q;
			dout_q <= dout_d;
		end
	end

	assign data_out          = dout_q;
	assign data_oe           = rd_act | ack_act;
	assign int_out           = int_q;
	assign cascade_lines_out = cas_out_q;
	assign cascade_lines_oe  = cas_oe_q;
	assign buffer_enable_n   = ~data_oe;
	assign slave_program_oe  = buf_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence first_ack_s;
		ack_go & ~pm_q & ~slave;
	endsequence
	sequence held_low_s;
		~ack_ns [*2];
	endsequence

	call_opcode_out_a: assert property (
		first_ack_s ##0 held_low_s
		|-> data_oe && dout_q == `PIC_CALL_OPCODE)
		else $error("call opcode not driven on first ack");
	ack_sets_isr_a: assert property (
		ack_go |=> svc_q[$past(ack_lvl)])
		else $error("first ack did not set in-service bit");
	vector_quiet_a: assert property (
		ready && pm_q && ack_cnt_q == 2'd0 && ack_ns == 1'b0
		&& rd_act == 1'b0 |-> !data_oe)
		else $error("bus driven on first vector ack");
	vector_byte_a: assert property (
		pm_q && ack_cnt_q == 2'd1 && !ack_ns && !ack_np && !slave
		&& !hand_off_q |-> dout_q == {word2_q[7:3], lvl_q})
		else $error("vector byte wrong");
	high_byte_a: assert property (
		!pm_q && ack_cnt_q == 2'd2 && !ack_ns && !ack_np
		|-> dout_q == word2_q)
		else $error("third call byte wrong");
	bus_release_a: assert property (
		cs_n && ack_ns |-> !data_oe)
		else $error("bus driven while idle");
	init_clears_a: assert property (
		w_init1 |=> mask_q == 8'h00 && !rd_svc_q && !smm_q
		&& low_q == `PIC_LOW_RESET ##1 mask_q == 8'h00)
		else $error("init start did not clear state");
	no_word4_a: assert property (
		w_init1 && !din_p[`PIC_W1_W4N] |=> !pm_q && !auto_q && !buf_q)
		else $error("fourth word functions not reset");
	short_init_a: assert property (
		state_q == pic_pkg::ST_WORD2 && solo_q && !w4n_q && w_odd
		|=> state_q == pic_pkg::ST_READY)
		else $error("init sequence length wrong");
	level_sense_a: assert property (
		lvlt_q && !w_init1 && !ack_go && !poll_take && !req_now[0]
		|=> !pnd_q[0])
		else $error("level request held after line fell");
endmodule : pic_host_side

// ===== src/pic_map.svh
// bit positions, reset values and codes of the interrupt controller
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
`define PIC_CALL_OPCODE 8'hcd
`define PIC_LOW_RESET   3'h7
`define PIC_W1_W4N      0
`define PIC_W1_SOLO     1
`define PIC_W1_IV4      2
`define PIC_W1_LVLT     3
`define PIC_W1_SEL      4
`define PIC_CMD_SEL     3
`define PIC_EOI_BIT     5
`define PIC_SL_BIT      6
`define PIC_ROT_BIT     7
`define PIC_RD_RIS      0
`define PIC_RD_RR       1
`define PIC_RD_POLL     2
`define PIC_RD_SMM      5
`define PIC_RD_ESMM     6
`define PIC_W4_PM       0
`define PIC_W4_AUTO     1
`define PIC_W4_MS       2
`define PIC_W4_BUF      3
`define PIC_W4_NEST     4
`define PIC_POLL_FLAG   7
`endif

// ===== src/pic_pkg.sv
// types shared by the interrupt controller
package pic_pkg;
	typedef enum logic [2:0] {
		ST_UNINIT,
		ST_WORD2,
		ST_WORD3,
		ST_WORD4,
		ST_READY
	} pic_init_t;
endpackage : pic_pkg

// ===== testbench/pic_cpu_model.sv
// processor bus model that drives the controller pins
`timescale 1ns/1ps
module pic_cpu_model (
	// clock
	input  wire logic       clk,
	// bus pins
	output logic            chip_sel_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            address_bit_zero,
	output logic            interrupt_acknowledge_strobe_n,
	output logic      [7:0] data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe
);
	initial begin
		chip_sel_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		address_bit_zero = 1'b0;
		interrupt_acknowledge_strobe_n = 1'b1;
		data_in = 8'h00;
	end
	// rd and wr never low together
	task automatic bus_write(input logic addr0, input logic [7:0] d);
		@(negedge clk);
		chip_sel_n = 1'b0;
		address_bit_zero = addr0;
		data_in = d;
		wr_n = 1'b0;
		repeat (5) @(negedge clk);
		wr_n = 1'b1;
		// data held past the late sampling point
		repeat (4) @(negedge clk);
		chip_sel_n = 1'b1;
		data_in = ~d;
		repeat (4) @(negedge clk);
	endtask : bus_write
	task automatic bus_read(input logic cs_n, input logic addr0,
		output logic [7:0] d, output logic oe);
		@(negedge clk);
		chip_sel_n = cs_n;
		address_bit_zero = addr0;
		rd_n = 1'b0;
		repeat (5) @(negedge clk);
		d = data_out;
		oe = data_oe;
		rd_n = 1'b1;
		chip_sel_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : bus_read
	task automatic ack(output logic [7:0] d, output logic oe);
		@(negedge clk);
		interrupt_acknowledge_strobe_n = 1'b0;
		repeat (5) @(negedge clk);
		d = data_out;
		oe = data_oe;
		interrupt_acknowledge_strobe_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask : ack
	// word three only when cascaded, four only when flagged
	task automatic init(input logic [7:0] w1, input logic [7:0] w2,
		input logic [7:0] w3, input logic [7:0] w4);
		bus_write(1'b0, w1);
		bus_write(1'b1, w2);
		if (!w1[1]) bus_write(1'b1, w3);
		if (w1[0]) bus_write(1'b1, w4);
	endtask : init
endmodule : pic_cpu_model

// ===== testbench/pic_host_side_tb.sv
// self-checking bench of the processor facing controller part
`timescale 1ns/1ps
`define PIC_CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
 $display("Error at %0t got %h exp %h", $time, g, e); end end
module pic_host_side_tb;
	logic       clk;
	logic       sys_rst;
	logic [7:0] request_lines;
	logic [2:0] cascade_lines_in;
	logic       slave_program_in;
	wire        chip_sel_n;
	wire        rd_n;
	wire        wr_n;
	wire        address_bit_zero;
	wire        ack_n;
	wire  [7:0] data_in;
	wire  [7:0] data_out;
	wire        data_oe;
	wire        int_out;
	wire  [2:0] cascade_lines_out;
	wire        cascade_lines_oe;
	wire        buffer_enable_n;
	wire        slave_program_oe;
	logic [7:0] rd_data;
	logic       rd_oe;
	int         failures;
	int         checked;
	pic_host_side DUT (
		.clk                            (clk),
		.sys_rst                        (sys_rst),
		.chip_sel_n                     (chip_sel_n),
		.rd_n                           (rd_n),
		.wr_n                           (wr_n),
		.address_bit_zero               (address_bit_zero),
		.interrupt_acknowledge_strobe_n (ack_n),
		.data_in                        (data_in),
		.data_out                       (data_out),
		.data_oe                        (data_oe),
		.int_out                        (int_out),
		.request_lines                  (request_lines),
		.cascade_lines_in               (cascade_lines_in),
		.cascade_lines_out              (cascade_lines_out),
		.cascade_lines_oe               (cascade_lines_oe),
		.slave_program_in               (slave_program_in),
		.buffer_enable_n                (buffer_enable_n),
		.slave_program_oe               (slave_program_oe)
	);
	pic_cpu_model u_cpu (
		.clk                            (clk),
		.chip_sel_n                     (chip_sel_n),
		.rd_n                           (rd_n),
		.wr_n                           (wr_n),
		.address_bit_zero               (address_bit_zero),
		.interrupt_acknowledge_strobe_n (ack_n),
		.data_in                        (data_in),
		.data_out                       (data_out),
		.data_oe                        (data_oe)
	);
	always #25 clk = ~clk;
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	task automatic rd_chk(input logic addr0, input logic [7:0] e);
		u_cpu.bus_read(1'b0, addr0, rd_data, rd_oe);
		`PIC_CHK(rd_data, e)
	endtask : rd_chk
	task automatic ack_chk(input logic [7:0] e);
		u_cpu.ack(rd_data, rd_oe);
		`PIC_CHK(rd_oe, 1'b1)
		`PIC_CHK(rd_data, e)
	endtask : ack_chk
	task automatic set_lines(input logic [7:0] v);
		@(negedge clk);
		request_lines = v;
		repeat (4) @(negedge clk);
	endtask : set_lines
	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		final_report();
	end
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		request_lines = 8'h00;
		cascade_lines_in = 3'h0;
		slave_program_in = 1'b1;
		failures = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		`PIC_CHK(data_oe, 1'b0)
		`PIC_CHK(int_out, 1'b0)
		// call mode, interval four, single
		u_cpu.init(8'hb6, 8'h12, 8'h00, 8'h00);
		u_cpu.bus_write(1'b1, 8'h01);
		rd_chk(1'b1, 8'h01);
		set_lines(8'h29);
		rd_chk(1'b0, 8'h29);
		`PIC_CHK(int_out, 1'b1)
		ack_chk(8'hcd);
		ack_chk(8'hac);
		ack_chk(8'h12);
		u_cpu.bus_write(1'b0, 8'h0b);
		rd_chk(1'b0, 8'h08);
		u_cpu.bus_write(1'b0, 8'h20);
		rd_chk(1'b0, 8'h00);
		u_cpu.bus_write(1'b0, 8'h0a);
		rd_chk(1'b0, 8'h21);
		u_cpu.bus_read(1'b1, 1'b0, rd_data, rd_oe);
		`PIC_CHK(rd_oe, 1'b0)
		$display("test call interval four done");
		// vector, level trigger, buffered master; init puts select back to pending
		u_cpu.bus_write(1'b0, 8'h0b);
		u_cpu.init(8'h1b, 8'h4f, 8'h00, 8'h0d);
		`PIC_CHK(slave_program_oe, 1'b1)
		`PIC_CHK(buffer_enable_n, 1'b1)
		rd_chk(1'b1, 8'h00);
		rd_chk(1'b0, 8'h29);
		u_cpu.ack(rd_data, rd_oe);
		`PIC_CHK(rd_oe, 1'b0)
		ack_chk(8'h48);
		u_cpu.bus_write(1'b0, 8'h20);
		$display("test vector level done");
		// no fourth word: back to call mode, interval eight
		set_lines(8'h00);
		u_cpu.init(8'hb2, 8'h12, 8'h00, 8'h00);
		`PIC_CHK(slave_program_oe, 1'b0)
		set_lines(8'h08);
		ack_chk(8'hcd);
		ack_chk(8'h98);
		ack_chk(8'h12);
		u_cpu.bus_write(1'b0, 8'h20);
		$display("test call interval eight done");
		// cascaded master, slave on line three
		set_lines(8'h00);
		u_cpu.init(8'hb4, 8'h12, 8'h08, 8'h00);
		set_lines(8'h08);
		ack_chk(8'hcd);
		`PIC_CHK(cascade_lines_out, 3'h3)
		`PIC_CHK(cascade_lines_oe, 1'b1)
		u_cpu.ack(rd_data, rd_oe);
		`PIC_CHK(rd_oe, 1'b0)
		u_cpu.ack(rd_data, rd_oe);
		u_cpu.bus_write(1'b0, 8'h20);
		$display("test cascade master done");
		final_report();
	end
endmodule : pic_host_side_tb
